/* File: hw/sbs_pkg.sv */
// Shared constants for the break, wake and synchronous master serial port
package sbs_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_WAKE = 5'h04;
  localparam logic [4:0] OFF_STAT = 5'h08;
  localparam logic [4:0] OFF_TXD = 5'h0c;
  localparam logic [4:0] OFF_RXD = 5'h10;
  localparam logic [4:0] OFF_BAUD = 5'h14;

  // ----------------------------------------------------------------
  // Control and wake register fields
  // ----------------------------------------------------------------
  localparam int CTRL_TRANSMIT_ENABLE_BIT = 0;
  localparam int CTRL_SEND_BREAK_REQUEST = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_CLOCK_SOURCE_MASTER_SELECT = 3;
  localparam int CTRL_SERIAL_PORT_ENABLE = 4;
  localparam int CTRL_SINGLE_RECEIVE_ENABLE = 5;
  localparam int CTRL_CONTINUOUS_RECEIVE_ENABLE = 6;
  localparam int CTRL_CLOCK_POLARITY_SELECT = 7;
  localparam int WAKE_WUE = 0;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_SHIFT_REGISTER_EMPTY_FLAG = 0;
  localparam int STAT_TRANSMIT_BUFFER_EMPTY_FLAG = 1;
  localparam int STAT_RECEIVE_COMPLETE_FLAG = 2;
  localparam int STAT_FRAMING_ERROR_FLAG = 3;
  localparam int STAT_BRK = 4;
  localparam int STAT_RIDLE = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h03;

  // ----------------------------------------------------------------
  // Frame shapes (bit counts and break pattern)
  // ----------------------------------------------------------------
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] NORM_BITS = 4'ha;
  localparam logic [3:0] BRK_BITS = 4'he;
  localparam logic [13:0] BRK_PATTERN = 14'h2000;

endpackage

/* File: hw/sbs_link_if.sv */
// Two-wire link between the serial port and its far-end partner
`timescale 1ns/1ps
interface sbs_link_if;
  logic dev_dt_o;
  logic dev_dt_oe_n;
  logic dev_ck_o;
  logic dev_ck_oe_n;
  logic par_dt_o;
  logic par_dt_oe_n;
  logic dt_line;
  logic ck_line;

  // Wire resolution, lines pulled high when nobody drives
  assign dt_line = !dev_dt_oe_n ? dev_dt_o : (!par_dt_oe_n ? par_dt_o : 1'b1);
  assign ck_line = !dev_ck_oe_n ? dev_ck_o : 1'b1;

  modport dev (input dt_line, input ck_line,
               output dev_dt_o, output dev_dt_oe_n, output dev_ck_o, output dev_ck_oe_n);
  modport par (input dt_line, input ck_line, output par_dt_o, output par_dt_oe_n);
endinterface

/* File: hw/sbs_dev.sv */
// Serial port end: break send, wake on break, async receive, sync master transmit
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
module sbs_dev (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [4:0] addr_i, // Register byte address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  sbs_link_if.dev link // Data and clock pins
);

  // ----------------------------------------------------------------
  // Types and declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {T_IDLE = 3'b001, T_ASYNC = 3'b010, T_SYNC = 3'b100} sbs_tx_t;
  typedef enum logic [3:0] {R_IDLE = 4'b0001, R_START = 4'b0010, R_DATA = 4'b0100,
                            R_STOP = 4'b1000} sbs_rx_t;

  sbs_tx_t tst_ff;
  sbs_rx_t rst_ff;
  logic [7:0] ctrl_ff, baud_ff, hold_ff, rxd_ff, rdata_ff, rsh_ff;
  logic [7:0] tcnt_ff, rcnt_ff;
  logic [13:0] tsr_ff;
  logic [3:0] tbits_ff, rbits_ff;
  logic hold_full_ff, tphase_ff, brk_ff, rphase_ff;
  logic wue_ff, wake_fall_ff, rc_ff, fe_ff;
  logic dt_ff, dt_oe_n_ff, ck_ff, ck_oe_n_ff;
  logic rx_s1_ff, rx_s2_ff, rx_prev_ff;
  logic pol, serial_port_enable, is_sync, async_ok, sync_tx_ok, sync_cfg;
  logic load, ttick, rtick, bit_end, brk_fin, fall, rise, rx_en;
  logic wr_ctrl, wr_txd, rd_rxd;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign pol = ctrl_ff[sbs_pkg::CTRL_CLOCK_POLARITY_SELECT];
  assign serial_port_enable = ctrl_ff[sbs_pkg::CTRL_SERIAL_PORT_ENABLE];
  assign is_sync = ctrl_ff[sbs_pkg::CTRL_SYNC];
  assign async_ok = serial_port_enable & ~is_sync;
  assign sync_cfg = serial_port_enable & is_sync & ctrl_ff[sbs_pkg::CTRL_CLOCK_SOURCE_MASTER_SELECT];
  assign sync_tx_ok = sync_cfg & ~ctrl_ff[sbs_pkg::CTRL_SINGLE_RECEIVE_ENABLE]
                      & ~ctrl_ff[sbs_pkg::CTRL_CONTINUOUS_RECEIVE_ENABLE];
  assign wr_ctrl = wr_i & (addr_i == sbs_pkg::OFF_CTRL);
  assign wr_txd = wr_i & (addr_i == sbs_pkg::OFF_TXD);
  assign rd_rxd = rd_i & (addr_i == sbs_pkg::OFF_RXD);
  assign load = (tst_ff == T_IDLE) & hold_full_ff & ctrl_ff[sbs_pkg::CTRL_TRANSMIT_ENABLE_BIT]
                & (async_ok | sync_tx_ok);
  assign ttick = (tcnt_ff == 8'h00);
  assign bit_end = ttick & tphase_ff;
  assign brk_fin = (tst_ff == T_ASYNC) & bit_end & (tbits_ff == 4'h1) & brk_ff;
  assign rtick = (rcnt_ff == 8'h00);
  assign fall = rx_prev_ff & ~rx_s2_ff;
  assign rise = ~rx_prev_ff & rx_s2_ff;
  assign rx_en = async_ok & ctrl_ff[sbs_pkg::CTRL_CONTINUOUS_RECEIVE_ENABLE] & ~wue_ff;

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= sbs_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= wdata_i;
    end else if (brk_fin) begin
      ctrl_ff[sbs_pkg::CTRL_SEND_BREAK_REQUEST] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      baud_ff <= sbs_pkg::BAUD_RST;
    end else if (wr_i && addr_i == sbs_pkg::OFF_BAUD) begin
      baud_ff <= wdata_i;
    end
  end

  // Holding register; a write while full is dropped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_ff <= 8'h00;
      hold_full_ff <= 1'b0;
    end else if (wr_txd && !hold_full_ff) begin
      hold_ff <= wdata_i;
      hold_full_ff <= 1'b1;
    end else if (load) begin
      hold_full_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter (not mapped to any address)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tcnt_ff <= 8'h00;
      tphase_ff <= 1'b0;
    end else if (load || ttick) begin
      tcnt_ff <= baud_ff;
      tphase_ff <= load ? 1'b0 : ~tphase_ff;
    end else begin
      tcnt_ff <= tcnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tst_ff <= T_IDLE;
      tsr_ff <= 14'h0000;
      tbits_ff <= 4'h0;
      brk_ff <= 1'b0;
    end else begin
      case (tst_ff)
        T_IDLE: begin
          if (load && !is_sync) begin
            tst_ff <= T_ASYNC;
            brk_ff <= ctrl_ff[sbs_pkg::CTRL_SEND_BREAK_REQUEST];
            if (ctrl_ff[sbs_pkg::CTRL_SEND_BREAK_REQUEST]) begin
              tsr_ff <= sbs_pkg::BRK_PATTERN;
              tbits_ff <= sbs_pkg::BRK_BITS;
            end else begin
              tsr_ff <= {5'h1f, hold_ff, 1'b0};
              tbits_ff <= sbs_pkg::NORM_BITS;
            end
          end else if (load) begin
            tst_ff <= T_SYNC;
            tsr_ff <= {6'h00, hold_ff};
            tbits_ff <= sbs_pkg::DATA_BITS;
          end
        end
        T_ASYNC, T_SYNC: begin
          if (bit_end) begin
            tsr_ff <= {1'b0, tsr_ff[13:1]};
            tbits_ff <= tbits_ff - 4'h1;
            if (tbits_ff == 4'h1) begin
              tst_ff <= T_IDLE;
            end
          end
        end
        default: tst_ff <= T_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ck_ff <= 1'b1;
      dt_ff <= 1'b1;
    end else if (tst_ff == T_IDLE) begin
      if (load && is_sync) begin
        dt_ff <= hold_ff[0];
        ck_ff <= ~pol;
      end else if (load) begin
        ck_ff <= 1'b0;
      end else if (is_sync) begin
        ck_ff <= pol;
      end else begin
        ck_ff <= 1'b1;
      end
    end else if (tst_ff == T_ASYNC) begin
      if (bit_end) begin
        ck_ff <= (tbits_ff == 4'h1) ? 1'b1 : tsr_ff[1];
      end
    end else if (ttick && !tphase_ff) begin
      ck_ff <= pol;
    end else if (bit_end && tbits_ff != 4'h1) begin
      dt_ff <= tsr_ff[1];
      ck_ff <= ~pol;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ck_oe_n_ff <= 1'b1;
      dt_oe_n_ff <= 1'b1;
    end else begin
      ck_oe_n_ff <= ~(async_ok | sync_cfg);
      dt_oe_n_ff <= ~sync_tx_ok;
    end
  end

  assign link.dev_dt_o = dt_ff;
  assign link.dev_dt_oe_n = dt_oe_n_ff;
  assign link.dev_ck_o = ck_ff;
  assign link.dev_ck_oe_n = ck_oe_n_ff;

  // ----------------------------------------------------------------
  // Receive line synchroniser and wake on break
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_s1_ff <= link.dt_line;
      rx_s2_ff <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
    end
  end

  // Cleared by the line edge alone, no other timing needed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wue_ff <= 1'b0;
      wake_fall_ff <= 1'b0;
    end else if (wr_i && addr_i == sbs_pkg::OFF_WAKE) begin
      wue_ff <= wdata_i[sbs_pkg::WAKE_WUE];
      wake_fall_ff <= 1'b0;
    end else if (wue_ff && fall) begin
      wake_fall_ff <= 1'b1;
    end else if (wue_ff && wake_fall_ff && rise) begin
      wue_ff <= 1'b0;
      wake_fall_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_ff <= R_IDLE;
      rcnt_ff <= 8'h00;
      rphase_ff <= 1'b0;
      rbits_ff <= 4'h0;
      rsh_ff <= 8'h00;
    end else begin
      rcnt_ff <= rtick ? baud_ff : rcnt_ff - 8'h01;
      if (rtick) begin
        rphase_ff <= ~rphase_ff;
      end
      case (rst_ff)
        R_IDLE: begin
          if (rx_en && fall) begin
            rst_ff <= R_START;
            rcnt_ff <= baud_ff;
          end
        end
        R_START: begin
          if (rtick) begin
            rst_ff <= rx_s2_ff ? R_IDLE : R_DATA;
            rphase_ff <= 1'b0;
            rbits_ff <= 4'h0;
          end
        end
        R_DATA: begin
          if (rtick && rphase_ff) begin
            rsh_ff <= {rx_s2_ff, rsh_ff[7:1]};
            rbits_ff <= rbits_ff + 4'h1;
            if (rbits_ff == sbs_pkg::DATA_BITS - 4'h1) begin
              rst_ff <= R_STOP;
            end
          end
        end
        R_STOP: begin
          if (rtick && rphase_ff) begin
            rst_ff <= R_IDLE;
          end
        end
        default: rst_ff <= R_IDLE;
      endcase
    end
  end

  // Receive flags; a new event wins over a clearing read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rc_ff <= 1'b0;
      fe_ff <= 1'b0;
      rxd_ff <= 8'h00;
    end else if (rst_ff == R_STOP && rtick && rphase_ff) begin
      rc_ff <= 1'b1;
      fe_ff <= ~rx_s2_ff;
      rxd_ff <= rsh_ff;
    end else if (wue_ff && fall) begin
      rc_ff <= 1'b1;
    end else if (rd_rxd) begin
      rc_ff <= 1'b0;
      fe_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !rd_i) begin
      rdata_ff <= 8'h00;
    end else begin
      case (addr_i)
        sbs_pkg::OFF_CTRL: rdata_ff <= ctrl_ff;
        sbs_pkg::OFF_WAKE: rdata_ff <= {7'h00, wue_ff};
        sbs_pkg::OFF_STAT: rdata_ff <= {2'b00, rst_ff == R_IDLE,
                                        rc_ff & fe_ff & (rxd_ff == 8'h00),
                                        fe_ff, rc_ff, ~hold_full_ff,
                                        tst_ff == T_IDLE};
        sbs_pkg::OFF_RXD: rdata_ff <= rxd_ff;
        sbs_pkg::OFF_BAUD: rdata_ff <= baud_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rdata_ff;

endmodule

/* File: hw/sbs_par.sv */
// Far-end partner: sync slave receiver, async frame sender and receiver
`timescale 1ns/1ps
module sbs_par (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [7:0] half_div_i, // Half bit period minus one, in clocks
  input wire logic sync_mode_i, // High: sync slave, low: async node
  input wire logic pol_i, // Clock idle level in sync mode
  input wire logic send_i, // Pulse: send one async frame
  input wire logic send_brk_i, // With send_i: send a break instead
  input wire logic [7:0] send_data_i, // Byte to send
  output logic busy_o, // Async frame in progress
  output logic rx_valid_o, // Pulse: async frame received
  output logic [7:0] rx_data_o, // Async received byte
  output logic rx_fe_o, // Framing error of that frame
  output logic rx_break_o, // That frame was a break
  output logic sync_valid_o, // Pulse: sync byte received
  output logic [7:0] sync_data_o, // Sync received byte
  sbs_link_if.par link // Data and clock pins
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ck_s1_ff, ck_s2_ff, ck_prev_ff, dt_s1_ff, dt_s2_ff;
  logic [7:0] tcnt_ff, rcnt_ff, ssh_ff, rsh_ff, rx_data_ff, sync_data_ff;
  logic [13:0] tsh_ff;
  logic [3:0] tbits_ff, rbits_ff, sbits_ff;
  logic busy_ff, tph_ff, rbusy_ff, rph_ff, oe_n_ff, dout_ff;
  logic rx_valid_ff, rx_fe_ff, rx_break_ff, sync_valid_ff;
  logic trail, tick;

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      {ck_s1_ff, ck_s2_ff, ck_prev_ff, dt_s1_ff, dt_s2_ff} <= 5'h1f;
    end else begin
      ck_s1_ff <= link.ck_line;
      ck_s2_ff <= ck_s1_ff;
      ck_prev_ff <= ck_s2_ff;
      dt_s1_ff <= link.dt_line;
      dt_s2_ff <= dt_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sync slave: sample data on trailing clock edges
  // ----------------------------------------------------------------
  assign trail = (ck_s2_ff == pol_i) & (ck_prev_ff != pol_i);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !sync_mode_i) begin
      sbits_ff <= 4'h0;
      ssh_ff <= 8'h00;
      sync_valid_ff <= 1'b0;
      sync_data_ff <= 8'h00;
    end else begin
      sync_valid_ff <= 1'b0;
      if (trail) begin
        ssh_ff <= {dt_s2_ff, ssh_ff[7:1]};
        sbits_ff <= (sbits_ff == sbs_pkg::DATA_BITS - 4'h1) ? 4'h0 : sbits_ff + 4'h1;
        if (sbits_ff == sbs_pkg::DATA_BITS - 4'h1) begin
          sync_valid_ff <= 1'b1;
          sync_data_ff <= {dt_s2_ff, ssh_ff[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Async sender on the data line, silent in sync mode
  // ----------------------------------------------------------------
  assign tick = (tcnt_ff == 8'h00);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      tph_ff <= 1'b0;
      tcnt_ff <= 8'h00;
      tsh_ff <= 14'h3fff;
      tbits_ff <= 4'h0;
    end else if (!busy_ff) begin
      if (send_i && !sync_mode_i) begin
        busy_ff <= 1'b1;
        tph_ff <= 1'b0;
        tcnt_ff <= half_div_i;
        tsh_ff <= send_brk_i ? sbs_pkg::BRK_PATTERN : {5'h1f, send_data_i, 1'b0};
        tbits_ff <= send_brk_i ? sbs_pkg::BRK_BITS : sbs_pkg::NORM_BITS;
      end
    end else begin
      tcnt_ff <= tick ? half_div_i : tcnt_ff - 8'h01;
      if (tick) begin
        tph_ff <= ~tph_ff;
      end
      if (tick && tph_ff) begin
        tsh_ff <= {1'b1, tsh_ff[13:1]};
        tbits_ff <= tbits_ff - 4'h1;
        busy_ff <= (tbits_ff != 4'h1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      oe_n_ff <= 1'b1;
      dout_ff <= 1'b1;
    end else begin
      oe_n_ff <= sync_mode_i | ~(busy_ff | send_i);
      dout_ff <= busy_ff ? tsh_ff[0] : ~send_i;
    end
  end

  // ----------------------------------------------------------------
  // Async receiver on the clock line, break check
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rbusy_ff <= 1'b0;
      rph_ff <= 1'b0;
      rcnt_ff <= 8'h00;
      rbits_ff <= 4'h0;
      rsh_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx_fe_ff <= 1'b0;
      rx_break_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (!rbusy_ff) begin
        if (!sync_mode_i && ck_prev_ff && !ck_s2_ff) begin
          rbusy_ff <= 1'b1;
          rph_ff <= 1'b1;
          rcnt_ff <= half_div_i;
          rbits_ff <= 4'h0;
        end
      end else begin
        rcnt_ff <= (rcnt_ff == 8'h00) ? half_div_i : rcnt_ff - 8'h01;
        if (rcnt_ff == 8'h00) begin
          rph_ff <= ~rph_ff;
          if (rph_ff) begin
            rbits_ff <= rbits_ff + 4'h1;
            rsh_ff <= {ck_s2_ff, rsh_ff[7:1]};
            if (rbits_ff == 4'h0 && ck_s2_ff) begin
              rbusy_ff <= 1'b0;
            end else if (rbits_ff == sbs_pkg::DATA_BITS + 4'h1) begin
              rbusy_ff <= 1'b0;
              rx_valid_ff <= 1'b1;
              rx_data_ff <= rsh_ff;
              rx_fe_ff <= ~ck_s2_ff;
              rx_break_ff <= ~ck_s2_ff & (rsh_ff == 8'h00);
            end
          end
        end
      end
    end
  end

  assign link.par_dt_o = dout_ff;
  assign link.par_dt_oe_n = oe_n_ff;
  assign busy_o = busy_ff;
  assign rx_valid_o = rx_valid_ff;
  assign rx_data_o = rx_data_ff;
  assign rx_fe_o = rx_fe_ff;
  assign rx_break_o = rx_break_ff;
  assign sync_valid_o = sync_valid_ff;
  assign sync_data_o = sync_data_ff;

endmodule

/* File: dv/sbs_link_checker.sv */
// Checker of drive rules and timing on the two-wire link
`timescale 1ns/1ps
module sbs_link_checker (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic dev_dt_o, // Device data out
  input wire logic dev_dt_oe_n, // Device data enable, low drives
  input wire logic dev_ck_o, // Device clock or transmit out
  input wire logic dev_ck_oe_n, // Device clock enable, low drives
  input wire logic par_dt_oe_n, // Partner data enable, low drives
  input wire logic dt_line, // Resolved data line
  input wire logic ck_line // Resolved clock line
);
  logic [7:0] lo_cnt_ff;
  logic [7:0] nxt_lo_cnt;
  // Low time of the async transmit pin
  assign nxt_lo_cnt = (!dev_ck_oe_n && dev_dt_oe_n && !dev_ck_o) ? lo_cnt_ff + 8'h01 : 8'h00;
  always_ff @(posedge clk_i) begin
    lo_cnt_ff <= rst_n_i ? nxt_lo_cnt : 8'h00;
  end
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_idle_a: assert property (disable iff (1'b0)
    !rst_n_i |=> dev_dt_oe_n && dev_ck_oe_n && par_dt_oe_n)
    else $error("pin drivers active after reset");
  half_duplex_a: assert property (!(!dev_dt_oe_n && !par_dt_oe_n))
    else $error("both ends drive the data line");
  ck_with_dt_a: assert property (!dev_dt_oe_n |-> !dev_ck_oe_n)
    else $error("data driven without clock driver");
  lead_edge_a: assert property (
    !dev_dt_oe_n && !$past(dev_dt_oe_n) && $changed(dev_dt_o) |-> $changed(dev_ck_o))
    else $error("data changed away from a clock edge");
  half_bit_a: assert property (!dev_ck_oe_n && $changed(dev_ck_o) |=> $stable(dev_ck_o) [*3])
    else $error("clock pin level shorter than half a bit");
  break_len_a: assert property (
    $rose(dev_ck_o) && dev_dt_oe_n && !dev_ck_oe_n |->
    lo_cnt_ff <= 8'h68 && lo_cnt_ff[2:0] == 3'h0)
    else $error("low run on transmit pin not whole bits or too long");
  high_bit_a: assert property (
    $fell(dev_ck_o) && dev_dt_oe_n && !dev_ck_oe_n |-> $past(dev_ck_o, 8))
    else $error("high run on transmit pin shorter than a bit");
  ck_wire_a: assert property (!dev_ck_oe_n |-> ck_line == dev_ck_o)
    else $error("clock line differs from device drive");
endmodule

/* File: dv/tb.sv */
// Testbench: device and partner joined over the link
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic sync_mode_i = 1'b0;
  logic pol_i = 1'b0;
  logic send_i = 1'b0;
  logic send_brk_i = 1'b0;
  logic [7:0] send_data_i = 8'h00;
  logic busy_o, rx_valid_o, rx_break_o, sync_valid_o, rx_fe_o;
  logic [7:0] rx_data_o, sync_data_o, v, d;
  logic [8:0] aq[$];
  logic [7:0] sq[$];
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  sbs_link_if lnk ();
  sbs_dev u_sbs_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(lnk.dev));
  sbs_par u_sbs_par (.clk_i(clk_i), .rst_n_i(rst_n_i), .half_div_i(8'h03),
    .sync_mode_i(sync_mode_i), .pol_i(pol_i), .send_i(send_i), .send_brk_i(send_brk_i),
    .send_data_i(send_data_i), .busy_o(busy_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_fe_o(rx_fe_o), .rx_break_o(rx_break_o), .sync_valid_o(sync_valid_o),
    .sync_data_o(sync_data_o), .link(lnk.par));
  sbs_link_checker u_sbs_link_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .dev_dt_o(lnk.dev_dt_o), .dev_dt_oe_n(lnk.dev_dt_oe_n), .dev_ck_o(lnk.dev_ck_o),
    .dev_ck_oe_n(lnk.dev_ck_oe_n), .par_dt_oe_n(lnk.par_dt_oe_n), .dt_line(lnk.dt_line),
    .ck_line(lnk.ck_line));
  initial forever #12.5 clk_i = ~clk_i;
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  always @(posedge clk_i) begin
    if (rx_valid_o) aq.push_back({rx_break_o, rx_data_o});
    if (sync_valid_o) sq.push_back(sync_data_o);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  function automatic logic [7:0] ctrl(input logic sy, input logic pl, input logic sb,
                                      input logic cr);
    logic [7:0] c;
    c = 8'h00;
    c[sbs_pkg::CTRL_TRANSMIT_ENABLE_BIT] = 1'b1;
    c[sbs_pkg::CTRL_SERIAL_PORT_ENABLE] = 1'b1;
    c[sbs_pkg::CTRL_SEND_BREAK_REQUEST] = sb;
    c[sbs_pkg::CTRL_SYNC] = sy;
    c[sbs_pkg::CTRL_CLOCK_SOURCE_MASTER_SELECT] = sy;
    c[sbs_pkg::CTRL_CONTINUOUS_RECEIVE_ENABLE] = cr;
    c[sbs_pkg::CTRL_CLOCK_POLARITY_SELECT] = pl;
    return c;
  endfunction
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] dt);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= dt;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic psend(input logic b, input logic [7:0] dt);
    @(posedge clk_i);
    send_i <= 1'b1;
    send_brk_i <= b;
    send_data_i <= dt;
    @(posedge clk_i);
    send_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 300 && busy_o !== 1'b0; i++) @(posedge clk_i);
    repeat (16) @(posedge clk_i);
  endtask
  task automatic wq(input int n, input logic s);
    for (int i = 0; i < 3000 && (s ? sq.size() : aq.size()) < n; i++) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    v = 8'($urandom(32'h24e14bff));
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(sbs_pkg::OFF_CTRL);
    chk("ctrl", {1'b0, v}, {1'b0, sbs_pkg::CTRL_RST});
    rd(sbs_pkg::OFF_BAUD);
    chk("baud", {1'b0, v}, {1'b0, sbs_pkg::BAUD_RST});
    rd(5'h1c);
    chk("unmapped", {1'b0, v}, 9'h000);
    rd(sbs_pkg::OFF_STAT);
    chk("stat idle", {7'h00, v[1:0]}, 9'h003);
    $display("test reset done");
    wr(sbs_pkg::OFF_CTRL, ctrl(1'b0, 1'b0, 1'b1, 1'b0));
    wr(sbs_pkg::OFF_TXD, 8'($urandom()));
    wr(sbs_pkg::OFF_TXD, 8'h55);
    wr(sbs_pkg::OFF_TXD, 8'hff);
    rd(sbs_pkg::OFF_STAT);
    chk("stat busy", {7'h00, v[1:0]}, 9'h000);
    wq(2, 1'b0);
    repeat (120) @(posedge clk_i);
    chk("frames", 9'(aq.size()), 9'h002);
    chk("break", aq[0], 9'h100);
    chk("sync", aq[1], 9'h055);
    chk("sync fe", {8'h00, rx_fe_o}, 9'h000);
    rd(sbs_pkg::OFF_CTRL);
    chk("send_break_request", {1'b0, v}, {1'b0, ctrl(1'b0, 1'b0, 1'b0, 1'b0)});
    $display("test break send done");
    wr(sbs_pkg::OFF_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b1));
    for (int i = 0; i < 3; i++) begin
      d = (i < 2) ? 8'h00 : 8'($urandom());
      psend(i == 0, d);
      rd(sbs_pkg::OFF_STAT);
      chk("rx stat", {6'h00, v[4:2]}, {6'h00, (i == 0) ? 3'b111 : 3'b001});
      rd(sbs_pkg::OFF_RXD);
      chk("rx data", {1'b0, v}, {1'b0, d});
    end
    $display("test break receive done");
    wr(sbs_pkg::OFF_WAKE, 8'h01);
    psend(1'b1, 8'h00);
    rd(sbs_pkg::OFF_WAKE);
    chk("wake clr", {1'b0, v}, 9'h000);
    rd(sbs_pkg::OFF_STAT);
    chk("wake stat", {6'h00, v[4:2]}, 9'h001);
    rd(sbs_pkg::OFF_RXD);
    d = 8'($urandom());
    psend(1'b0, d);
    rd(sbs_pkg::OFF_RXD);
    chk("wake data", {1'b0, v}, {1'b0, d});
    $display("test wake done");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_i);
      sync_mode_i <= 1'b0;
      pol_i <= p[0];
      wr(sbs_pkg::OFF_CTRL, ctrl(1'b1, p[0], 1'b0, 1'b0));
      repeat (6) @(posedge clk_i);
      sync_mode_i <= 1'b1;
      sq.delete();
      d = 8'($urandom());
      wr(sbs_pkg::OFF_TXD, d);
      wr(sbs_pkg::OFF_TXD, ~d);
      wq(2, 1'b1);
      repeat (10) @(posedge clk_i);
      chk("sync b0", {1'b0, sq[0]}, {1'b0, d});
      chk("sync b1", {1'b0, sq[1]}, {1'b0, ~d});
      chk("ck idle", {8'h00, lnk.ck_line}, {8'h00, p[0]});
      chk("dt drive", {8'h00, lnk.dev_dt_oe_n}, 9'h000);
    end
    wr(sbs_pkg::OFF_CTRL, ctrl(1'b1, 1'b1, 1'b0, 1'b1));
    sq.delete();
    wr(sbs_pkg::OFF_TXD, 8'h3c);
    repeat (100) @(posedge clk_i);
    chk("rx mode", 9'(sq.size()), 9'h000);
    chk("ck drive", {8'h00, lnk.dev_ck_oe_n}, 9'h000);
    $display("test sync master done");
    wrap_up();
  end
endmodule
